// ---- include/ivp_pkg.sv ----
// constants, tables and types for the interrupt vector and priority block
// assumes the core fetches from the vector offset handed to it, in words
package ivp_pkg;

  // widths
  localparam int NUM_SRC = 14;
  localparam int OFS_W   = 7;
  localparam int PRI_W   = 5;
  localparam int NUM_W   = 5;
  localparam int BIT_W   = 4;
  localparam int PIN_NUM = 6;

  typedef logic [OFS_W-1:0]   ivp_ofs_t;
  typedef logic [PRI_W-1:0]   ivp_pri_t;
  typedef logic [NUM_SRC-1:0] ivp_vec_t;

  // fixed vectors and levels for the non-maskable slots
  localparam ivp_ofs_t OFS_RESET   = 7'h00;
  localparam ivp_ofs_t OFS_NMI     = 7'h04;
  localparam ivp_ofs_t OFS_TRAP_LO = 7'h08;
  localparam ivp_ofs_t OFS_TRAP_HI = 7'h3C;
  localparam ivp_ofs_t OFS_RSVD_LO = 7'h78;
  localparam ivp_pri_t PRI_RESET   = 5'h01;
  localparam ivp_pri_t PRI_NMI     = 5'h02;
  localparam ivp_pri_t PRI_NONE    = 5'h00;

  // bit positions shared by pending flags and enable mask
  localparam int BIT_EXT0  = 0;
  localparam int BIT_EXT1  = 1;
  localparam int BIT_EXT2  = 2;
  localparam int BIT_TIMER = 3;
  localparam int BIT_SP0RX = 4;
  localparam int BIT_SP0TX = 5;
  localparam int BIT_SP2RX = 6;
  localparam int BIT_SP2TX = 7;
  localparam int BIT_EXT3  = 8;
  localparam int BIT_HOST  = 9;
  localparam int BIT_SP1RX = 10;
  localparam int BIT_SP1TX = 11;
  localparam int BIT_DMA4  = 12;
  localparam int BIT_DMA5  = 13;

  // per-bit vector offset and level, index is the bit position
  localparam ivp_ofs_t SRC_OFS [NUM_SRC] = '{7'h40, 7'h44, 7'h48, 7'h4C, 7'h50, 7'h54, 7'h58,
                                             7'h5C, 7'h60, 7'h64, 7'h68, 7'h6C, 7'h70, 7'h74};
  localparam ivp_pri_t SRC_PRI [NUM_SRC] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                                             5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10};

  // software trap numbering and slot numbers
  localparam logic [NUM_W-1:0] TRAP_MASK_LAST = 5'h0D;
  localparam logic [NUM_W-1:0] TRAP_NMI_NUM   = 5'h10;
  localparam logic [NUM_W-1:0] TRAP_LAST      = 5'h1E;
  localparam logic [NUM_W-1:0] TRAP_BIAS      = 5'h0F;
  localparam logic [NUM_W-1:0] SLOT_RESET     = 5'h00;
  localparam logic [NUM_W-1:0] SLOT_NMI       = 5'h01;

  // values after reset
  localparam ivp_vec_t FLAG_RST = 14'h0000;
  localparam ivp_vec_t MASK_RST = 14'h0000;
  localparam logic [PIN_NUM-1:0] PIN_IDLE = 6'h3F;

  typedef enum logic [2:0] {K_NONE, K_RESET, K_NMI, K_TRAP, K_MASK} ivp_kind_t;

endpackage

// ---- verilog/ivp_vector_rom.sv ----
// vector slot table: slot number in, registered offset and level out
// assumes en is a one-cycle load from the arbiter on the same clock
`timescale 1ns/1ps
module ivp_vector_rom (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    en,
  input  wire logic [ivp_pkg::NUM_W-1:0] slotNum,
  output ivp_pkg::ivp_ofs_t            vecOfs_q,
  output ivp_pkg::ivp_pri_t            vecPri_q
);

  ivp_pkg::ivp_ofs_t ofsLook;
  ivp_pkg::ivp_pri_t priLook;

  // offset is four words per slot, levels from the source table or the fixed reset and nmi levels
  always_comb begin
    ofsLook = {slotNum, 2'b00};
    priLook = ivp_pkg::PRI_NONE;
    if (slotNum == ivp_pkg::SLOT_RESET) begin
      priLook = ivp_pkg::PRI_RESET;
    end else if (slotNum == ivp_pkg::SLOT_NMI) begin
      priLook = ivp_pkg::PRI_NMI;
    end
    for (int i = 0; i < ivp_pkg::NUM_SRC; i++) begin
      if (ivp_pkg::SRC_OFS[i][6:2] == slotNum) begin
        priLook = ivp_pkg::SRC_PRI[i];
      end
    end
  end

  // output register, held between loads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vecOfs_q <= ivp_pkg::OFS_RESET;
      vecPri_q <= ivp_pkg::PRI_NONE;
    end else if (en) begin
      vecOfs_q <= ofsLook;
      vecPri_q <= priLook;
    end
  end

endmodule // ivp_vector_rom

// ---- verilog/ivp_vector_priority.sv ----
// interrupt vectoring and fixed priority for the signal processor core
// assumes pins are asynchronous and active low; events are one-cycle pulses on clk
// Functional notes
// - hardware and software reset use offset 0x00 at level 1
// - nmi at 0x04 level 2, timer 0x4C level 6, host port 0x64 level 12
// - traps 17 to 30 own offsets 0x08 to 0x3C with no level
// - external pin 0 uses offset 0x40 at level 3
// - external pin 1 uses offset 0x44 at level 4
// - external pin 2 uses offset 0x48 at level 5
// - external pin 3 uses offset 0x60 at level 11
// - serial port 0 receive uses 0x50 at level 7
// - serial port 0 transmit uses 0x54 at level 8
// - serial port 2 receive uses 0x58 at level 9
// - serial port 2 transmit uses 0x5C at level 10
// - serial port 1 receive uses 0x68 at level 13
// - serial port 1 transmit uses 0x6C at level 14
// - dma channel 4 uses 0x70 at level 15
// - dma channel 5 uses 0x74 at level 16, lowest
// - pending flags and enable mask share one bit layout
`timescale 1ns/1ps
module ivp_vector_priority (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       hwResetRequestN,
  input  wire logic                       nmiRequestN,
  input  wire logic [3:0]                 extRequestN,
  input  wire logic                       softResetTrap,
  input  wire logic                       swTrapValid,
  input  wire logic [ivp_pkg::NUM_W-1:0]  swTrapNum,
  input  wire logic                       timerEvent,
  input  wire logic                       sp0RxEvent,
  input  wire logic                       sp0TxEvent,
  input  wire logic                       sp1RxEvent,
  input  wire logic                       sp1TxEvent,
  input  wire logic                       sp2RxEvent,
  input  wire logic                       sp2TxEvent,
  input  wire logic                       hostPortEvent,
  input  wire logic                       dmaCh4Event,
  input  wire logic                       dmaCh5Event,
  input  wire logic                       intGlobalEn,
  input  wire logic                       maskWrEn,
  input  wire logic [ivp_pkg::NUM_SRC-1:0] maskWrData,
  input  wire logic                       flagClrEn,
  input  wire logic [ivp_pkg::NUM_SRC-1:0] flagClrData,
  input  wire logic                       intAck,
  output logic                            intReq,
  output ivp_pkg::ivp_ofs_t               intVector,
  output ivp_pkg::ivp_pri_t               intPriority,
  output ivp_pkg::ivp_vec_t               pendingFlags,
  output ivp_pkg::ivp_vec_t               enableMask
);

  logic [ivp_pkg::PIN_NUM-1:0] pinRaw;
  logic [ivp_pkg::PIN_NUM-1:0] syncA_q;
  logic [ivp_pkg::PIN_NUM-1:0] syncB_q;
  logic [ivp_pkg::PIN_NUM-1:0] pinPrev_q;
  logic [3:0]                  extFall;
  logic                        nmiFall;
  logic                        hwResetLvl;

  ivp_pkg::ivp_vec_t           evtVec;
  ivp_pkg::ivp_vec_t           flags_q;
  ivp_pkg::ivp_vec_t           flags_d;
  ivp_pkg::ivp_vec_t           mask_q;
  ivp_pkg::ivp_vec_t           mask_d;
  ivp_pkg::ivp_vec_t           clrVec;
  ivp_pkg::ivp_vec_t           ackBitVec;
  ivp_pkg::ivp_vec_t           maskPend;
  ivp_pkg::ivp_vec_t           lowerBits;

  logic                        resetPend_q;
  logic                        resetPend_d;
  logic                        nmiPend_q;
  logic                        nmiPend_d;
  logic                        trapPend_q;
  logic                        trapPend_d;
  logic [ivp_pkg::NUM_W-1:0]   trapSlot_q;
  logic [ivp_pkg::NUM_W-1:0]   trapSlot_d;
  logic                        trapLegal;
  logic [ivp_pkg::NUM_W-1:0]   trapSlotNew;

  logic                        anyMask;
  logic [ivp_pkg::BIT_W-1:0]   winBit;
  ivp_pkg::ivp_kind_t          winKind;
  logic [ivp_pkg::NUM_W-1:0]   winSlot;
  logic                        load;
  logic                        ack;
  logic                        resetTaken;

  logic                        reqValid_q;
  logic                        reqValid_d;
  ivp_pkg::ivp_kind_t          presKind_q;
  logic [ivp_pkg::BIT_W-1:0]   presBit_q;

  // pins are asynchronous, so two flops before any edge logic
  assign pinRaw = {hwResetRequestN, nmiRequestN, extRequestN};

  for (genvar g = 0; g < ivp_pkg::PIN_NUM; g++) begin : gen_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        syncA_q[g]   <= ivp_pkg::PIN_IDLE[g];
        syncB_q[g]   <= ivp_pkg::PIN_IDLE[g];
        pinPrev_q[g] <= ivp_pkg::PIN_IDLE[g];
      end else begin
        syncA_q[g]   <= pinRaw[g];
        syncB_q[g]   <= syncA_q[g];
        pinPrev_q[g] <= syncB_q[g];
      end
    end
  end

  // falling edges latch requests; reset pin acts as a level
  assign extFall    = pinPrev_q[3:0] & ~syncB_q[3:0];
  assign nmiFall    = pinPrev_q[4] & ~syncB_q[4];
  assign hwResetLvl = ~syncB_q[5];

  assign evtVec[ivp_pkg::BIT_EXT0]  = extFall[0];
  assign evtVec[ivp_pkg::BIT_EXT1]  = extFall[1];
  assign evtVec[ivp_pkg::BIT_EXT2]  = extFall[2];
  assign evtVec[ivp_pkg::BIT_TIMER] = timerEvent;
  assign evtVec[ivp_pkg::BIT_SP0RX] = sp0RxEvent;
  assign evtVec[ivp_pkg::BIT_SP0TX] = sp0TxEvent;
  assign evtVec[ivp_pkg::BIT_SP2RX] = sp2RxEvent;
  assign evtVec[ivp_pkg::BIT_SP2TX] = sp2TxEvent;
  assign evtVec[ivp_pkg::BIT_EXT3]  = extFall[3];
  assign evtVec[ivp_pkg::BIT_HOST]  = hostPortEvent;
  assign evtVec[ivp_pkg::BIT_SP1RX] = sp1RxEvent;
  assign evtVec[ivp_pkg::BIT_SP1TX] = sp1TxEvent;
  assign evtVec[ivp_pkg::BIT_DMA4]  = dmaCh4Event;
  assign evtVec[ivp_pkg::BIT_DMA5]  = dmaCh5Event;

  // trap slot mapping
  // traps 0..13 reuse maskable slots without the mask; 14, 15, 31 are dropped
  assign trapLegal   = swTrapValid && ((swTrapNum <= ivp_pkg::TRAP_MASK_LAST) ||
                       ((swTrapNum >= ivp_pkg::TRAP_NMI_NUM) && (swTrapNum <= ivp_pkg::TRAP_LAST)));
  assign trapSlotNew = (swTrapNum <= ivp_pkg::TRAP_MASK_LAST) ? {1'b1, swTrapNum[3:0]} :
                       (swTrapNum == ivp_pkg::TRAP_NMI_NUM)  ? ivp_pkg::SLOT_NMI :
                       swTrapNum - ivp_pkg::TRAP_BIAS;

  // mask and global enable gate only maskable bits
  assign maskPend = flags_q & mask_q & {ivp_pkg::NUM_SRC{intGlobalEn}};
  assign anyMask  = |maskPend;

  // lowest bit is the smallest level number
  always_comb begin
    winBit = '0;
    for (int i = ivp_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (maskPend[i]) begin
        winBit = 4'(i);
      end
    end
  end

  // reset and nmi sit above the mask path
  assign winKind = resetPend_q ? ivp_pkg::K_RESET :
                   nmiPend_q   ? ivp_pkg::K_NMI   :
                   trapPend_q  ? ivp_pkg::K_TRAP  :
                   anyMask     ? ivp_pkg::K_MASK  : ivp_pkg::K_NONE;

  assign winSlot = (winKind == ivp_pkg::K_RESET) ? ivp_pkg::SLOT_RESET :
                   (winKind == ivp_pkg::K_NMI)   ? ivp_pkg::SLOT_NMI   :
                   (winKind == ivp_pkg::K_TRAP)  ? trapSlot_q :
                   ivp_pkg::SRC_OFS[winBit][6:2];

  // a presented request stands until taken; one idle cycle after each take
  assign load       = !reqValid_q && (winKind != ivp_pkg::K_NONE);
  assign ack        = intAck && reqValid_q;
  assign resetTaken = ack && (presKind_q == ivp_pkg::K_RESET);
  assign reqValid_d = load ? 1'b1 : (ack ? 1'b0 : reqValid_q);

  for (genvar b = 0; b < ivp_pkg::NUM_SRC; b++) begin : gen_ack
    assign ackBitVec[b] = ack && (presKind_q == ivp_pkg::K_MASK) && (presBit_q == 4'(b));
  end

  // one layout for flags and mask; new events win over any clear
  assign clrVec  = ({ivp_pkg::NUM_SRC{flagClrEn}} & flagClrData) | ackBitVec |
                   {ivp_pkg::NUM_SRC{resetTaken}};
  assign flags_d = (flags_q & ~clrVec) | evtVec;
  assign mask_d  = resetTaken ? ivp_pkg::MASK_RST : (maskWrEn ? maskWrData : mask_q);

  // single-bit pendings, set over clear
  assign resetPend_d = hwResetLvl || softResetTrap || (resetPend_q && !resetTaken);
  assign nmiPend_d   = nmiFall || (nmiPend_q && !(ack && (presKind_q == ivp_pkg::K_NMI))
                       && !resetTaken);
  assign trapPend_d  = trapLegal || (trapPend_q && !(ack && (presKind_q == ivp_pkg::K_TRAP))
                       && !resetTaken);
  assign trapSlot_d  = trapLegal ? trapSlotNew : trapSlot_q;

  // pending state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q     <= ivp_pkg::FLAG_RST;
      mask_q      <= ivp_pkg::MASK_RST;
      resetPend_q <= 1'b0;
      nmiPend_q   <= 1'b0;
      trapPend_q  <= 1'b0;
      trapSlot_q  <= ivp_pkg::SLOT_RESET;
    end else begin
      flags_q     <= flags_d;
      mask_q      <= mask_d;
      resetPend_q <= resetPend_d;
      nmiPend_q   <= nmiPend_d;
      trapPend_q  <= trapPend_d;
      trapSlot_q  <= trapSlot_d;
    end
  end

  // presented request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reqValid_q <= 1'b0;
      presKind_q <= ivp_pkg::K_NONE;
      presBit_q  <= '0;
    end else begin
      reqValid_q <= reqValid_d;
      if (load) begin
        presKind_q <= winKind;
        presBit_q  <= winBit;
      end
    end
  end

  // offset and level table, registered on load
  ivp_vector_rom u_rom (
    .clk      (clk),
    .rst_n    (rst_n),
    .en       (load),
    .slotNum  (winSlot),
    .vecOfs_q (intVector),
    .vecPri_q (intPriority)
  );

  assign intReq       = reqValid_q;
  assign pendingFlags = flags_q;
  assign enableMask   = mask_q;

  // checks, all on clk; rst_n low holds them off
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // enabled pending bits below the winner, empty when the pick is right
  assign lowerBits = maskPend & ((ivp_pkg::NUM_SRC'(1) << winBit) - ivp_pkg::NUM_SRC'(1));

  chk_reset_vector: assert property (
    reqValid_q && presKind_q == ivp_pkg::K_RESET |-> intVector == 7'h00 && intPriority == 5'h01)
    else $error("reset vector or level wrong");

  chk_nmi_vector: assert property (
    reqValid_q && presKind_q == ivp_pkg::K_NMI |-> intVector == 7'h04 && intPriority == 5'h02)
    else $error("nmi vector or level wrong");

  chk_trap_window: assert property (
    reqValid_q && intVector >= 7'h08 && intVector <= 7'h3C |-> intPriority == 5'h00)
    else $error("trap slot carries a level");

  chk_mask_table: assert property (
    reqValid_q && presKind_q == ivp_pkg::K_MASK |->
      intVector == ivp_pkg::SRC_OFS[presBit_q] && intPriority == ivp_pkg::SRC_PRI[presBit_q])
    else $error("maskable vector or level wrong");

  chk_dma_last: assert property (
    reqValid_q && presKind_q == ivp_pkg::K_MASK && presBit_q == 4'hD |->
      intVector == 7'h74 && intPriority == 5'h10)
    else $error("lowest slot wrong");

  chk_event_sets: assert property (
    |evtVec |=> (flags_q & $past(evtVec)) == $past(evtVec))
    else $error("event lost in flag register");

  chk_lowest_first: assert property (
    load && winKind == ivp_pkg::K_MASK |-> lowerBits == '0)
    else $error("higher level skipped");

  // flag, mask and global enable all needed
  chk_mask_gate: assert property (
    load && winKind == ivp_pkg::K_MASK |-> flags_q[winBit] && mask_q[winBit] && intGlobalEn)
    else $error("masked source taken");

  chk_no_reserved: assert property (
    reqValid_q |-> intVector < 7'h78)
    else $error("reserved vector used");

  chk_ack_clears: assert property (
    ack && presKind_q == ivp_pkg::K_MASK && !evtVec[presBit_q] |=>
      !flags_q[$past(presBit_q)] && !reqValid_q)
    else $error("taken flag not cleared");

  // a presented request stands until the core takes it
  chk_req_holds: assert property (
    reqValid_q && !intAck |=> reqValid_q && $stable(intVector))
    else $error("presented request changed");

  // mask write lands unless a reset take wins
  chk_mask_write: assert property (
    maskWrEn && !resetTaken |=> mask_q == $past(maskWrData))
    else $error("mask write lost");

  // software clear empties the named flags
  chk_flag_clear: assert property (
    flagClrEn && evtVec == '0 |=> (flags_q & $past(flagClrData)) == '0)
    else $error("cleared flag still set");

  // reset take empties flags and mask
  chk_reset_clears: assert property (
    resetTaken && evtVec == '0 |=>
      flags_q == ivp_pkg::FLAG_RST && mask_q == ivp_pkg::MASK_RST)
    else $error("reset take left state");

  // nmi goes ahead of traps and maskable bits
  chk_nmi_first: assert property (
    load && nmiPend_q && !resetPend_q |=> presKind_q == ivp_pkg::K_NMI)
    else $error("nmi not taken first");

  // request drops for one cycle after each take
  chk_idle_gap: assert property (
    ack |=> !reqValid_q)
    else $error("request not dropped after take");

  // numbers without a slot never become pending
  chk_trap_drop: assert property (
    swTrapValid && (swTrapNum == 5'h0E || swTrapNum == 5'h0F || swTrapNum == 5'h1F)
      && !trapPend_q |=> !trapPend_q)
    else $error("unused trap number pending");

  // main scenarios worth seeing at least once
  cov_reset_taken: cover property (resetTaken);
  cov_nmi_taken:   cover property (ack && presKind_q == ivp_pkg::K_NMI);
  cov_trap_taken:  cover property (ack && presKind_q == ivp_pkg::K_TRAP);
  cov_mask_race:   cover property (load && winKind == ivp_pkg::K_MASK && lowerBits == '0
                                   && $countones(maskPend) > 1);
  cov_pin_event:   cover property (extFall != '0);

endmodule // ivp_vector_priority

// ---- test/ivp_core_model.sv ----
// behavioural core sequencer that takes presented vectors
// assumes request and vector stand until intAck on the same clock
`timescale 1ns/1ps
module ivp_core_model (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              intReq,
  input  wire ivp_pkg::ivp_ofs_t intVector,
  input  wire ivp_pkg::ivp_pri_t intPriority,
  input  wire logic [3:0]        ackDelay,
  output logic                   intAck,
  output ivp_pkg::ivp_ofs_t      takenVec,
  output ivp_pkg::ivp_pri_t      takenPri,
  output logic [7:0]             takenCnt
);
  logic [3:0] waitCnt;

  // ack after ackDelay cycles; a slow core checks that the request holds
  always @(posedge clk) begin
    if (!rst_n) begin
      intAck   <= 1'b0;
      waitCnt  <= 4'h0;
      takenVec <= 7'h00;
      takenPri <= 5'h00;
      takenCnt <= 8'h00;
    end else if (intAck) begin
      intAck  <= 1'b0; // one-cycle ack, request drops at this edge
      waitCnt <= 4'h0;
    end else if (intReq && waitCnt == ackDelay) begin
      intAck   <= 1'b1;
      takenVec <= intVector;
      takenPri <= intPriority;
      takenCnt <= takenCnt + 8'h01;
    end else if (intReq) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule // ivp_core_model

// ---- test/testbench.sv ----
// self-checking bench for the vector and priority block
// assumes the core model acks presented vectors; inputs move 1 ns after clk rises
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, hwRstN, nmiN, softRst, trapValid, globalEn, mWrEn, fClrEn;
  logic [4:0] trapNum;
  logic [13:0] evt, mWrData, fClrData;
  logic [3:0] ackDelay;
  logic intAck, intReq;
  ivp_pkg::ivp_ofs_t intVector, takenVec;
  ivp_pkg::ivp_pri_t intPriority, takenPri;
  ivp_pkg::ivp_vec_t pendingFlags, enableMask;
  logic [7:0] takenCnt;
  int err_total = 0;
  int comparisons = 0;
  // expected offset and level per flag bit
  localparam logic [6:0] EXP_OFS [14] = '{7'h40, 7'h44, 7'h48, 7'h4C, 7'h50, 7'h54, 7'h58,
                                          7'h5C, 7'h60, 7'h64, 7'h68, 7'h6C, 7'h70, 7'h74};
  localparam logic [4:0] EXP_PRI [14] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                                          5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10};

  ivp_vector_priority i_ivp_vector_priority (
    .clk(clk), .rst_n(rst_n), .hwResetRequestN(hwRstN), .nmiRequestN(nmiN),
    .extRequestN(~{evt[8], evt[2], evt[1], evt[0]}), .softResetTrap(softRst),
    .swTrapValid(trapValid), .swTrapNum(trapNum), .timerEvent(evt[3]),
    .sp0RxEvent(evt[4]), .sp0TxEvent(evt[5]), .sp1RxEvent(evt[10]), .sp1TxEvent(evt[11]),
    .sp2RxEvent(evt[6]), .sp2TxEvent(evt[7]), .hostPortEvent(evt[9]),
    .dmaCh4Event(evt[12]), .dmaCh5Event(evt[13]), .intGlobalEn(globalEn),
    .maskWrEn(mWrEn), .maskWrData(mWrData), .flagClrEn(fClrEn), .flagClrData(fClrData),
    .intAck(intAck), .intReq(intReq), .intVector(intVector), .intPriority(intPriority),
    .pendingFlags(pendingFlags), .enableMask(enableMask));

  ivp_core_model i_ivp_core_model (
    .clk(clk), .rst_n(rst_n), .intReq(intReq), .intVector(intVector),
    .intPriority(intPriority), .ackDelay(ackDelay), .intAck(intAck),
    .takenVec(takenVec), .takenPri(takenPri), .takenCnt(takenCnt));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chkBit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkFlags(input string nm, input ivp_pkg::ivp_vec_t e, input ivp_pkg::ivp_vec_t g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkTake(input ivp_pkg::ivp_ofs_t eVec, input ivp_pkg::ivp_pri_t ePri);
    logic [7:0] startCnt;
    int n;
    startCnt = takenCnt;
    n = 0;
    // bounded wait for the core model to take a vector
    while (takenCnt == startCnt && n < 30) begin
      cyc(1);
      n++;
    end
    chkBit("taken", 1'b1, takenCnt != startCnt);
    comparisons++;
    if (takenVec !== eVec || takenPri !== ePri) begin
      err_total++;
      $display("BAD vector expected %h/%h seen %h/%h", eVec, ePri, takenVec, takenPri);
    end
  endtask

  task automatic pulse(input logic [13:0] bits);
    evt = bits;
    cyc(1);
    evt = 14'h0000;
  endtask

  task automatic setMask(input logic [13:0] m);
    mWrEn = 1'b1;
    mWrData = m;
    cyc(1);
    mWrEn = 1'b0;
  endtask

  task automatic trap(input logic [4:0] n);
    trapValid = 1'b1;
    trapNum = n;
    cyc(1);
    trapValid = 1'b0;
  endtask

  task automatic testReset;
    chkFlags("flagsRst", 14'h0000, pendingFlags);
    chkFlags("maskRst", 14'h0000, enableMask);
    chkBit("reqRst", 1'b0, intReq);
  endtask

  // every maskable source: flag position, masking, vector, flag cleared on take
  task automatic testEachSource;
    for (int b = 0; b < 14; b++) begin
      pulse(14'h0001 << b);
      cyc(4);
      chkFlags("flagBit", 14'h0001 << b, pendingFlags);
      chkBit("masked", 1'b0, intReq);
      setMask(14'h0001 << b);
      chkFlags("maskBit", 14'h0001 << b, enableMask);
      chkTake(EXP_OFS[b], EXP_PRI[b]); // to
      cyc(2);
      chkFlags("flagTaken", 14'h0000, pendingFlags);
    end
    // software clear of a masked pending flag
    setMask(14'h0000);
    pulse(14'h0008);
    cyc(4);
    chkFlags("flagSet", 14'h0008, pendingFlags);
    fClrEn = 1'b1;
    fClrData = 14'h0008;
    cyc(1);
    fClrEn = 1'b0;
    cyc(1);
    chkFlags("flagClr", 14'h0000, pendingFlags);
  endtask

  // three pending at once, slow core: smallest level first
  task automatic testPriority;
    globalEn = 1'b0;
    ackDelay = 4'h3;
    setMask(14'h3FFF);
    pulse(14'h2208);
    cyc(4);
    chkBit("gated", 1'b0, intReq);
    globalEn = 1'b1;
    chkTake(7'h4C, 5'h06);
    chkTake(7'h64, 5'h0C);
    chkTake(7'h74, 5'h10);
    ackDelay = 4'h0;
  endtask

  // traps 17 to 30, 16 and one maskable slot, then unused numbers that must not vector
  task automatic testTraps;
    for (int n = 17; n <= 30; n++) begin
      trap(5'(n));
      chkTake(7'(8 + 4 * (n - 17)), 5'h00);
    end
    trap(5'h10);
    chkTake(7'h04, 5'h02);
    trap(5'h05);
    chkTake(7'h54, 5'h08);
    trap(5'h0E);
    cyc(1);
    trap(5'h1F);
    cyc(10);
    chkBit("noReq", 1'b0, intReq);
  endtask

  // nmi and both resets ignore mask and global enable
  task automatic testNmiReset;
    setMask(14'h0000);
    globalEn = 1'b0;
    nmiN = 1'b0;
    cyc(1);
    nmiN = 1'b1;
    chkTake(7'h04, 5'h02);
    setMask(14'h3FFF);
    softRst = 1'b1;
    cyc(1);
    softRst = 1'b0;
    chkTake(7'h00, 5'h01);
    cyc(2);
    chkFlags("maskCleared", 14'h0000, enableMask);
    hwRstN = 1'b0;
    chkTake(7'h00, 5'h01);
    hwRstN = 1'b1;
    cyc(10); // level pin may be taken again while the sync drains
    globalEn = 1'b1;
  endtask

  // reset in mid-run drops pending flags; events count again from the first edge after
  task automatic testMidReset;
    setMask(14'h0000);
    pulse(14'h0010);
    cyc(2);
    chkFlags("flagsPre", 14'h0010, pendingFlags);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    chkFlags("flagsMid", 14'h0000, pendingFlags);
    chkBit("reqMid", 1'b0, intReq);
    pulse(14'h0010);
    cyc(1);
    chkFlags("flagsAfter", 14'h0010, pendingFlags);
  endtask

  task automatic results;
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    hwRstN = 1'b1;
    nmiN = 1'b1;
    softRst = 1'b0;
    trapValid = 1'b0;
    trapNum = 5'h00;
    globalEn = 1'b1;
    mWrEn = 1'b0;
    mWrData = 14'h0000;
    fClrEn = 1'b0;
    fClrData = 14'h0000;
    evt = 14'h0000;
    ackDelay = 4'h0;
    cyc(2);
    rst_n = 1'b1;
    testReset();
    cyc(3);
    testEachSource();
    testPriority();
    testTraps();
    testNmiReset();
    testMidReset();
    results();
  end
endmodule // testbench
